// *** logic/lsm_pkg.sv ***
package lsm_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS          = 10;
	localparam int DOMINANT_TIMEOUT_US    = 6000;
	localparam int DOMINANT_TIMEOUT_CYC   = (DOMINANT_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int TX_RELEASE_NS          = 10000;
	localparam int TX_RELEASE_CYC         = (TX_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IGNITION_DEBOUNCE_NS   = 160000;
	localparam int IGNITION_DEBOUNCE_CYC  = (IGNITION_DEBOUNCE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int RESET_INTERVAL_US      = 4000;
	localparam int RESET_INTERVAL_CYC     = (RESET_INTERVAL_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int WAKE_FILTER_NS         = 30000;
	localparam int WAKE_FILTER_CYC        = WAKE_FILTER_NS / CLK_PERIOD_NS;
	localparam int BUS_WAKE_NS            = 30000;
	localparam int BUS_WAKE_CYC           = BUS_WAKE_NS / CLK_PERIOD_NS;
	localparam int TRIG_MIN_NS            = 1000;
	localparam int TRIG_MIN_CYC           = (TRIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WDOG_OSC_DIV           = 100;
	localparam int WDOG_TIMEOUT_TICKS     = 200;
	localparam int CNT_W                  = 24;

	// ==========================================================
	// Modes
	typedef enum logic [1:0] {
		LSM_FAILSAFE,
		LSM_NORMAL,
		LSM_SILENT,
		LSM_SLEEP
	} lsm_mode_t;

endpackage

// *** logic/lsm_filter.sv ***
// ==========================================================
// Three-flop input synchroniser with agree-to-change filter.
module lsm_filter #(
	parameter logic INIT = 1'b1
) (
	input  wire logic sys_clk,
	input  wire logic reset,
	input  wire logic pin_in,
	output logic      level
);

	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic lvl_d;
	logic lvl_q;

	always_comb begin
		lvl_d = lvl_q;
		if (s2_q == s3_q) begin
			lvl_d = s3_q;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s1_q  <= INIT;
			s2_q  <= INIT;
			s3_q  <= INIT;
			lvl_q <= INIT;
		end else begin
			s1_q  <= pin_in;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	assign level = lvl_q;

endmodule // lsm_filter

// *** logic/lsm_core.sv ***
module lsm_core
	import lsm_pkg::*;
#(
	parameter int DOM_CYC  = DOMINANT_TIMEOUT_CYC,
	parameter int IGN_CYC  = IGNITION_DEBOUNCE_CYC,
	parameter int RES_CYC  = RESET_INTERVAL_CYC,
	parameter int WDOG_DIV = WDOG_OSC_DIV,
	parameter int WDOG_TO  = WDOG_TIMEOUT_TICKS
) (
	input  wire logic sys_clk,
	input  wire logic reset,
	input  wire logic txd_in,
	output logic      txd_out,
	output logic      txd_oe_n,
	input  wire logic lin_in,
	output logic      lin_out,
	output logic      lin_oe_n,
	output logic      rxd,
	input  wire logic enable,
	input  wire logic wake_n,
	input  wire logic ignition_in,
	input  wire logic wdog_trigger_n,
	input  wire logic wdog_debug,
	input  wire logic battery_supply_ok,
	input  wire logic vcc_undervoltage,
	output logic      ext_reg_inhibit,
	output logic      vcc_enable,
	output logic      combined_reset_n,
	output logic      combined_reset_oe_n,
	output lsm_mode_t mode
);

	// ==========================================================
	// Synchronised inputs
	logic tx_s;
	logic lin_s;
	logic en_s;
	logic wake_s;
	logic ign_s;
	logic trig_s;
	logic dbg_s;
	logic bat_s;
	logic uv_s;

	lsm_filter #(.INIT(1'b1)) u_tx   (.sys_clk(sys_clk), .reset(reset), .pin_in(txd_in),
		.level(tx_s));
	lsm_filter #(.INIT(1'b1)) u_lin  (.sys_clk(sys_clk), .reset(reset), .pin_in(lin_in),
		.level(lin_s));
	lsm_filter #(.INIT(1'b0)) u_en   (.sys_clk(sys_clk), .reset(reset), .pin_in(enable),
		.level(en_s));
	lsm_filter #(.INIT(1'b1)) u_wake (.sys_clk(sys_clk), .reset(reset), .pin_in(wake_n),
		.level(wake_s));
	lsm_filter #(.INIT(1'b0)) u_ign  (.sys_clk(sys_clk), .reset(reset), .pin_in(ignition_in),
		.level(ign_s));
	lsm_filter #(.INIT(1'b1)) u_trig (.sys_clk(sys_clk), .reset(reset),
		.pin_in(wdog_trigger_n), .level(trig_s));
	lsm_filter #(.INIT(1'b0)) u_dbg  (.sys_clk(sys_clk), .reset(reset), .pin_in(wdog_debug),
		.level(dbg_s));
	lsm_filter #(.INIT(1'b0)) u_bat  (.sys_clk(sys_clk), .reset(reset),
		.pin_in(battery_supply_ok), .level(bat_s));
	lsm_filter #(.INIT(1'b1)) u_uv   (.sys_clk(sys_clk), .reset(reset),
		.pin_in(vcc_undervoltage), .level(uv_s));

	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
		sat_inc = (v == {CNT_W{1'b1}}) ? v : v + 1'b1;
	endfunction

	// ==========================================================
	// State
	lsm_mode_t        mode_q, mode_d;
	logic             en_q, en_d;
	logic             ign_q, ign_d;
	logic             trig_q, trig_d;
	logic [CNT_W-1:0] dom_cnt_q, dom_cnt_d;
	logic [CNT_W-1:0] rel_cnt_q, rel_cnt_d;
	logic             dom_lock_q, dom_lock_d;
	logic [CNT_W-1:0] ign_cnt_q, ign_cnt_d;
	logic             ign_arm_q, ign_arm_d;
	logic [CNT_W-1:0] wake_cnt_q, wake_cnt_d;
	logic             wake_arm_q, wake_arm_d;
	logic [CNT_W-1:0] bus_cnt_q, bus_cnt_d;
	logic             bus_arm_q, bus_arm_d;
	logic [CNT_W-1:0] res_cnt_q, res_cnt_d;
	logic [CNT_W-1:0] trg_cnt_q, trg_cnt_d;
	logic [CNT_W-1:0] osc_cnt_q, osc_cnt_d;
	logic [CNT_W-1:0] wd_cnt_q, wd_cnt_d;
	logic             wd_fail_q, wd_fail_d;
	logic             local_wake_q, local_wake_d;
	logic             woke_q, woke_d;

	logic ign_wake;
	logic pin_wake;
	logic bus_wake;
	logic en_rise;
	logic en_fall;
	logic rst_low;
	logic lowpower;

	always_comb begin
		mode_d       = mode_q;
		en_d         = en_s;
		ign_d        = ign_s;
		trig_d       = trig_s;
		dom_cnt_d    = dom_cnt_q;
		rel_cnt_d    = rel_cnt_q;
		dom_lock_d   = dom_lock_q;
		ign_cnt_d    = ign_cnt_q;
		ign_arm_d    = ign_arm_q;
		wake_cnt_d   = wake_cnt_q;
		wake_arm_d   = wake_arm_q;
		bus_cnt_d    = bus_cnt_q;
		bus_arm_d    = bus_arm_q;
		res_cnt_d    = res_cnt_q;
		trg_cnt_d    = trg_cnt_q;
		osc_cnt_d    = osc_cnt_q;
		wd_cnt_d     = wd_cnt_q;
		wd_fail_d    = wd_fail_q;
		local_wake_d = local_wake_q;
		woke_d       = woke_q;
		en_rise      = en_s && !en_q;
		en_fall      = !en_s && en_q;
		lowpower     = (mode_q == LSM_SILENT) || (mode_q == LSM_SLEEP);
		ign_wake     = 1'b0;
		pin_wake     = 1'b0;
		bus_wake     = 1'b0;

		// Dominant time-out and release.
		if (!tx_s) begin
			rel_cnt_d = '0;
			dom_cnt_d = sat_inc(dom_cnt_q);
			if (dom_cnt_q >= CNT_W'(DOM_CYC)) begin
				dom_lock_d = 1'b1;
			end
		end else begin
			dom_cnt_d = '0;
			rel_cnt_d = sat_inc(rel_cnt_q);
			if (rel_cnt_q >= CNT_W'(TX_RELEASE_CYC)) begin
				dom_lock_d = 1'b0;
			end
		end

		// Ignition: only a rising edge arms the debounce; a steady high arms nothing.
		if (ign_s && !ign_q) begin
			ign_arm_d = 1'b1;
			ign_cnt_d = '0;
		end else if (!ign_s) begin
			ign_arm_d = 1'b0;
		end else if (ign_arm_q) begin
			ign_cnt_d = sat_inc(ign_cnt_q);
			if (ign_cnt_q >= CNT_W'(IGN_CYC)) begin
				ign_wake  = 1'b1;
				ign_arm_d = 1'b0;
			end
		end

		// Local wake: falling edge then low for the filter time.
		if (wake_s) begin
			wake_arm_d = 1'b1;
			wake_cnt_d = '0;
		end else if (wake_arm_q) begin
			wake_cnt_d = sat_inc(wake_cnt_q);
			if (wake_cnt_q >= CNT_W'(WAKE_FILTER_CYC)) begin
				pin_wake   = 1'b1;
				wake_arm_d = 1'b0;
			end
		end

		// Bus wake: dominant long enough, then the rising edge.
		if (!lin_s) begin
			bus_cnt_d = sat_inc(bus_cnt_q);
			if (bus_cnt_q >= CNT_W'(BUS_WAKE_CYC)) begin
				bus_arm_d = 1'b1;
			end
		end else begin
			bus_cnt_d = '0;
			bus_arm_d = 1'b0;
			bus_wake  = bus_arm_q;
		end

		// Mode control.
		rst_low = (res_cnt_q != '0) || uv_s || wd_fail_q;
		if (res_cnt_q != '0) begin
			res_cnt_d = res_cnt_q - 1'b1;
		end
		if (rst_low) begin
			mode_d = LSM_FAILSAFE;
		end else begin
			case (mode_q)
				LSM_FAILSAFE: begin
					if (en_s) begin
						mode_d = LSM_NORMAL;
					end
				end
				LSM_NORMAL: begin
					if (en_fall) begin
						mode_d = tx_s ? LSM_SILENT : LSM_SLEEP;
						woke_d = 1'b0;
					end
				end
				LSM_SILENT, LSM_SLEEP: begin
					if (!bat_s) begin
						mode_d = LSM_FAILSAFE;
					end else if (en_rise) begin
						mode_d = LSM_NORMAL;
					end else if (bus_wake || pin_wake || ign_wake) begin
						mode_d       = LSM_FAILSAFE;
						woke_d       = 1'b1;
						local_wake_d = pin_wake || ign_wake;
					end
				end
				default: mode_d = LSM_FAILSAFE;
			endcase
		end
		if (mode_q == LSM_NORMAL) begin
			woke_d       = 1'b0;
			local_wake_d = 1'b0;
		end

		// Watchdog on an oscillator time base; a short low is no trigger.
		osc_cnt_d = (osc_cnt_q >= CNT_W'(WDOG_DIV - 1)) ? '0 : osc_cnt_q + 1'b1;
		if (!trig_s) begin
			trg_cnt_d = trig_q ? CNT_W'(1) : sat_inc(trg_cnt_q);
		end else begin
			trg_cnt_d = '0;
		end
		if (dbg_s || lowpower || uv_s) begin
			wd_cnt_d  = '0;
			wd_fail_d = 1'b0;
		end else if (trg_cnt_q == CNT_W'(TRIG_MIN_CYC)) begin
			wd_cnt_d  = '0;
			wd_fail_d = 1'b0;
		end else if (osc_cnt_q == '0) begin
			wd_cnt_d = sat_inc(wd_cnt_q);
			if (wd_cnt_q >= CNT_W'(WDOG_TO)) begin
				wd_fail_d = 1'b1;
				wd_cnt_d  = '0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			mode_q       <= LSM_FAILSAFE;
			en_q         <= 1'b0;
			ign_q        <= 1'b0;
			trig_q       <= 1'b1;
			dom_cnt_q    <= '0;
			rel_cnt_q    <= '0;
			dom_lock_q   <= 1'b0;
			ign_cnt_q    <= '0;
			ign_arm_q    <= 1'b0;
			wake_cnt_q   <= '0;
			wake_arm_q   <= 1'b0;
			bus_cnt_q    <= '0;
			bus_arm_q    <= 1'b0;
			res_cnt_q    <= CNT_W'(RES_CYC);
			trg_cnt_q    <= '0;
			osc_cnt_q    <= '0;
			wd_cnt_q     <= '0;
			wd_fail_q    <= 1'b0;
			local_wake_q <= 1'b0;
			woke_q       <= 1'b0;
		end else begin
			mode_q       <= mode_d;
			en_q         <= en_d;
			ign_q        <= ign_d;
			trig_q       <= trig_d;
			dom_cnt_q    <= dom_cnt_d;
			rel_cnt_q    <= rel_cnt_d;
			dom_lock_q   <= dom_lock_d;
			ign_cnt_q    <= ign_cnt_d;
			ign_arm_q    <= ign_arm_d;
			wake_cnt_q   <= wake_cnt_d;
			wake_arm_q   <= wake_arm_d;
			bus_cnt_q    <= bus_cnt_d;
			bus_arm_q    <= bus_arm_d;
			res_cnt_q    <= res_cnt_d;
			trg_cnt_q    <= trg_cnt_d;
			osc_cnt_q    <= osc_cnt_d;
			wd_cnt_q     <= wd_cnt_d;
			wd_fail_q    <= wd_fail_d;
			local_wake_q <= local_wake_d;
			woke_q       <= woke_d;
		end
	end

	// ==========================================================
	// Outputs
	logic drive_dom_q;
	logic rxd_q;
	logic txd_oe_q;
	logic inh_q;
	logic vcc_q;
	logic rst_oe_q;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			drive_dom_q <= 1'b0;
			rxd_q       <= 1'b1;
			txd_oe_q    <= 1'b1;
			inh_q       <= 1'b0;
			vcc_q       <= 1'b1;
			rst_oe_q    <= 1'b0;
		end else begin
			// Battery-supply gating keeps a collapsing battery from sending junk frames.
			drive_dom_q <= (mode_q == LSM_NORMAL) && !tx_s && !dom_lock_q && bat_s;
			rxd_q       <= (mode_q == LSM_NORMAL) ? lin_s :
				(mode_q == LSM_SLEEP) ? 1'b0 : !woke_q;
			txd_oe_q    <= !((mode_q == LSM_FAILSAFE) && local_wake_q);
			inh_q       <= !lowpower && !uv_s && (res_cnt_q == '0 || !uv_s);
			vcc_q       <= (mode_q != LSM_SLEEP);
			rst_oe_q    <= !(uv_s || wd_fail_q || res_cnt_q != '0);
		end
	end

	assign lin_out             = 1'b0;
	assign lin_oe_n            = !drive_dom_q;
	assign rxd                 = rxd_q;
	assign txd_out             = 1'b0;
	assign txd_oe_n            = txd_oe_q;
	assign ext_reg_inhibit     = inh_q;
	assign vcc_enable          = vcc_q;
	assign combined_reset_n    = 1'b0;
	assign combined_reset_oe_n = rst_oe_q;
	assign mode                = mode_q;

endmodule // lsm_core

// *** dv/lsm_assertions.sv ***
// ==========================================================
// Port checker for the mode controller.
module lsm_assertions
	import lsm_pkg::*;
#(
	parameter int DOM_CYC = 50
) (
	input wire logic      sys_clk,
	input wire logic      reset,
	input wire logic      lin_in,
	input wire logic      lin_oe_n,
	input wire logic      rxd,
	input wire logic      battery_supply_ok,
	input wire logic      vcc_undervoltage,
	input wire logic      ext_reg_inhibit,
	input wire logic      vcc_enable,
	input wire logic      combined_reset_oe_n,
	input wire lsm_mode_t mode
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	// A stuck driver would hold the bus for good, so its low run is counted.
	int dom_d;
	int dom_q;
	always_comb dom_d = lin_oe_n ? 0 : dom_q + 1;
	always_ff @(posedge sys_clk) dom_q <= reset ? 0 : dom_d;

	property p_dom; dom_q <= DOM_CYC + 2; endproperty
	a_dom: assert property (p_dom) else $error("driver held too long");
	property p_drv; !lin_oe_n |-> mode == LSM_NORMAL || $past(mode) == LSM_NORMAL; endproperty
	a_drv: assert property (p_drv) else $error("driver on outside normal");
	property p_bat; (!battery_supply_ok)[*8] |-> lin_oe_n; endproperty
	a_bat: assert property (p_bat) else $error("driver on at low battery");
	property p_rxd; (mode == LSM_NORMAL && !lin_in)[*8] |-> !rxd; endproperty
	a_rxd: assert property (p_rxd) else $error("receive misses dominant");
	property p_uvr; vcc_undervoltage[*8] |-> !combined_reset_oe_n; endproperty
	a_uvr: assert property (p_uvr) else $error("no reset on undervoltage");
	property p_uvi; vcc_undervoltage[*8] |-> !ext_reg_inhibit; endproperty
	a_uvi: assert property (p_uvi) else $error("inhibit on during reset");
	property p_fs; (!combined_reset_oe_n)[*3] |-> mode == LSM_FAILSAFE; endproperty
	a_fs: assert property (p_fs) else $error("reset without fail-safe");
	property p_slp; (mode == LSM_SLEEP)[*2] |-> !vcc_enable; endproperty
	a_slp: assert property (p_slp) else $error("regulator on in sleep");
	property p_inh; (mode == LSM_SLEEP || mode == LSM_SILENT)[*2] |-> !ext_reg_inhibit; endproperty
	a_inh: assert property (p_inh) else $error("inhibit on in low power");
	property p_por; $fell(reset) |-> (!combined_reset_oe_n)[*8]; endproperty
	a_por: assert property (p_por) else $error("power-up reset too short");
endmodule // lsm_assertions

// *** dv/lsm_host_model.sv ***
// ==========================================================
// Host side watchdog service: mode 0 idle, 1 proper pulses, 2 too short.
module lsm_host_model
	import lsm_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic [1:0] trig_mode,
	output logic            wdog_trigger_n
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt_q;
	always_ff @(posedge sys_clk) begin
		cnt_q <= (reset || cnt_q == 199) ? 0 : cnt_q + 1;
		// Falling edge opens each period; idle level is high.
		wdog_trigger_n <= reset || trig_mode == 2'h0
			|| cnt_q >= (trig_mode == 2'h1 ? TRIG_MIN_CYC + 10 : TRIG_MIN_CYC / 2);
	end
endmodule // lsm_host_model

// *** dv/lin_sbc_mode_control_tb.sv ***
module lin_sbc_mode_control_tb
	import lsm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic      sys_clk, reset, txd_drv, txd_in, txd_out, txd_oe_n, bus_drv, lin_in;
	logic      lin_out, lin_oe_n, rxd, enable, wake_n, ignition_in, wdog_trigger_n;
	logic      wdog_debug, battery_supply_ok, vcc_undervoltage, ext_reg_inhibit;
	logic      vcc_enable, combined_reset_n, combined_reset_oe_n;
	logic [1:0] trig_mode;
	lsm_mode_t mode;
	int        bad_count, n_checks, cycles, lows;

	// Pulled-up pins: the device wins when it pulls low.
	assign txd_in = txd_drv & txd_oe_n;
	assign lin_in = bus_drv & lin_oe_n;

	lsm_core #(.DOM_CYC(50), .IGN_CYC(20), .RES_CYC(30), .WDOG_DIV(20), .WDOG_TO(20)) uut (
		.sys_clk(sys_clk), .reset(reset), .txd_in(txd_in), .txd_out(txd_out),
		.txd_oe_n(txd_oe_n), .lin_in(lin_in), .lin_out(lin_out), .lin_oe_n(lin_oe_n),
		.rxd(rxd), .enable(enable), .wake_n(wake_n), .ignition_in(ignition_in),
		.wdog_trigger_n(wdog_trigger_n), .wdog_debug(wdog_debug),
		.battery_supply_ok(battery_supply_ok), .vcc_undervoltage(vcc_undervoltage),
		.ext_reg_inhibit(ext_reg_inhibit), .vcc_enable(vcc_enable),
		.combined_reset_n(combined_reset_n), .combined_reset_oe_n(combined_reset_oe_n),
		.mode(mode));
	lsm_host_model u_host (.sys_clk(sys_clk), .reset(reset), .trig_mode(trig_mode),
		.wdog_trigger_n(wdog_trigger_n));

	always #5 sys_clk = ~sys_clk;

	task automatic conclude;
		if (bad_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			conclude();
		end
	end

	task automatic check(input logic [1:0] seen, input logic [1:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %0t: saw %b expected %b", $time, seen, exp);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask

	task automatic watch(input int n);
		lows = 0;
		repeat (n) begin
			@(negedge sys_clk);
			if (combined_reset_oe_n !== 1'b1)
				lows++;
		end
	endtask

	task automatic t_power;
		check(mode, LSM_FAILSAFE);
		check({vcc_enable, combined_reset_oe_n}, 2'h2);
		settle(40);
		check({1'b0, combined_reset_oe_n}, 2'h1);
		check(mode, LSM_FAILSAFE);
	endtask

	task automatic t_normal;
		@(posedge sys_clk);
		enable <= 1'b1;
		settle(10);
		check(mode, LSM_NORMAL);
		check({1'b0, ext_reg_inhibit}, 2'h1);
		@(posedge sys_clk);
		txd_drv <= 1'b0;
		settle(10);
		check({lin_oe_n, rxd}, 2'h0);
		check({lin_out, lin_oe_n}, 2'h0);
		settle(60);
		check({lin_oe_n, rxd}, 2'h3);
		@(posedge sys_clk);
		txd_drv <= 1'b1;
		settle(20);
		@(posedge sys_clk);
		txd_drv <= 1'b0;
		settle(10);
		check({1'b0, lin_oe_n}, 2'h1);
		@(posedge sys_clk);
		txd_drv <= 1'b1;
		settle(1010);
		@(posedge sys_clk);
		txd_drv <= 1'b0;
		settle(10);
		check({1'b0, lin_oe_n}, 2'h0);
		@(posedge sys_clk);
		battery_supply_ok <= 1'b0;
		settle(10);
		check({1'b0, lin_oe_n}, 2'h1);
		@(posedge sys_clk);
		txd_drv <= 1'b1;
		battery_supply_ok <= 1'b1;
		settle(10);
		check({lin_oe_n, rxd}, 2'h3);
	endtask

	task automatic t_silent;
		@(posedge sys_clk);
		enable <= 1'b0;
		settle(10);
		check(mode, LSM_SILENT);
		check({ext_reg_inhibit, vcc_enable}, 2'h1);
		@(posedge sys_clk);
		wake_n <= 1'b0;
		settle(3010);
		@(posedge sys_clk);
		wake_n <= 1'b1;
		settle(10);
		check(mode, LSM_FAILSAFE);
		check({rxd, txd_oe_n}, 2'h0);
		check({txd_out, combined_reset_n}, 2'h0);
		@(posedge sys_clk);
		enable <= 1'b1;
		settle(10);
	endtask

	task automatic t_sleep;
		@(posedge sys_clk);
		txd_drv <= 1'b0;
		enable <= 1'b0;
		settle(10);
		check(mode, LSM_SLEEP);
		check({vcc_enable, ext_reg_inhibit}, 2'h0);
		@(posedge sys_clk);
		txd_drv <= 1'b1;
		ignition_in <= 1'b1;
		settle(10);
		@(posedge sys_clk);
		ignition_in <= 1'b0;
		settle(30);
		check(mode, LSM_SLEEP);
		@(posedge sys_clk);
		ignition_in <= 1'b1;
		settle(40);
		check(mode, LSM_FAILSAFE);
		check({rxd, txd_oe_n}, 2'h0);
		@(posedge sys_clk);
		enable <= 1'b1;
		settle(10);
		@(posedge sys_clk);
		enable <= 1'b0;
		settle(60);
		check(mode, LSM_SILENT);
		@(posedge sys_clk);
		enable <= 1'b1;
		ignition_in <= 1'b0;
		settle(10);
		check(mode, LSM_NORMAL);
		@(posedge sys_clk);
		enable <= 1'b0;
		settle(10);
		@(posedge sys_clk);
		bus_drv <= 1'b0;
		settle(3010);
		@(posedge sys_clk);
		bus_drv <= 1'b1;
		settle(10);
		check(mode, LSM_FAILSAFE);
		check({rxd, txd_oe_n}, 2'h1);
	endtask

	task automatic t_uv_wdog;
		// Start from normal mode so the forced fall-back is visible.
		@(posedge sys_clk);
		enable <= 1'b1;
		settle(10);
		check(mode, LSM_NORMAL);
		@(posedge sys_clk);
		vcc_undervoltage <= 1'b1;
		settle(10);
		check({combined_reset_oe_n, ext_reg_inhibit}, 2'h0);
		check(mode, LSM_FAILSAFE);
		@(posedge sys_clk);
		vcc_undervoltage <= 1'b0;
		wdog_debug <= 1'b0;
		trig_mode <= 2'h1;
		settle(50);
		watch(1200);
		check({1'b0, lows == 0}, 2'h1);
		@(posedge sys_clk);
		trig_mode <= 2'h2;
		watch(1200);
		check({1'b0, lows == 0}, 2'h0);
		@(posedge sys_clk);
		wdog_debug <= 1'b1;
		trig_mode <= 2'h0;
		settle(50);
		watch(1200);
		check({1'b0, lows == 0}, 2'h1);
	endtask

	initial begin
		{sys_clk, bad_count, n_checks, cycles, trig_mode, enable, vcc_undervoltage} = '0;
		{reset, txd_drv, bus_drv, wake_n, wdog_debug, battery_supply_ok} = '1;
		ignition_in = 1'b0;
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		settle(1);
		t_power();
		t_normal();
		t_silent();
		t_sleep();
		t_uv_wdog();
		conclude();
	end
endmodule // lin_sbc_mode_control_tb

bind lsm_core lsm_assertions #(.DOM_CYC(DOM_CYC)) u_chk (.sys_clk(sys_clk), .reset(reset),
	.lin_in(lin_in), .lin_oe_n(lin_oe_n), .rxd(rxd), .battery_supply_ok(battery_supply_ok),
	.vcc_undervoltage(vcc_undervoltage), .ext_reg_inhibit(ext_reg_inhibit),
	.vcc_enable(vcc_enable), .combined_reset_oe_n(combined_reset_oe_n), .mode(mode));
